// file: verilog/ppac_pkg.sv
/*
 Shared constants, types and timing for the parallel asynchronous
 configuration port. Assumes a 125 MHz core clock standing in for the
 internal byte-processing oscillator.
*/
package ppac_pkg;
	// Clock and timing figures
	localparam int CLK_NS = 8;
	localparam int POR_LONG_MS = 100;
	localparam int POR_SHORT_MS = 12;
	localparam int POR_LONG_CYC = POR_LONG_MS * 1000000 / CLK_NS;
	localparam int POR_SHORT_CYC = POR_SHORT_MS * 1000000 / CLK_NS;
	localparam int ERR_TMO_US = 100;
	localparam int ERR_TMO_CYC = ERR_TMO_US * 1000 / CLK_NS;
	localparam int BUSY_NS = 32;
	localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
	localparam int INIT_OSC_NS = 100;
	localparam int INIT_CLKS = 299;
	localparam int INIT_INT_CYC = (INIT_CLKS * INIT_OSC_NS + CLK_NS - 1) / CLK_NS;
	localparam int D2U_NS = 1000;
	localparam int D2U_CYC = (D2U_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = 24;
	localparam int UCNT_W = 9;
	typedef logic [TMR_W-1:0] ppac_tmr_t;

	// Mode pin codes and header flag bits
	localparam logic [3:0] MODE_PLAIN = 4'h1;
	localparam logic [3:0] MODE_UPGRADE = 4'h5;
	localparam int HDR_CMP_BIT = 0;
	localparam int HDR_SEC_BIT = 1;

	// Register map, byte addresses
	localparam int AW = 8;
	localparam logic [AW-1:0] A_CTRL = 8'h00;
	localparam logic [AW-1:0] A_FLEN = 8'h04;
	localparam logic [AW-1:0] A_STAT = 8'h08;
	localparam logic [AW-1:0] A_BCNT = 8'h0C;
	localparam logic [AW-1:0] A_LAST = 8'h10;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] FLEN_RST = 32'h0000_0010;

	// Synchroniser bit positions and idle values
	localparam int S_WS = 0;
	localparam int S_RS = 1;
	localparam int S_SL = 2;
	localparam int S_SH = 3;
	localparam int S_RST = 4;
	localparam int S_STAT = 5;
	localparam int S_DONE = 6;
	localparam int S_UCLK = 7;
	localparam int S_W = 8;
	localparam logic [S_W-1:0] SYNC_RST = 8'h07;

	typedef enum logic [3:0] {
		ST_PORA, ST_POR, ST_RESET, ST_CONFIG, ST_ERROR, ST_INITD, ST_INIT, ST_USER
	} ppac_stage_e;

	typedef struct packed {
		logic [29:0] rsvd;
		logic use_uclk;
		logic auto_rst;
	} ppac_ctrl_s;

	typedef struct packed {
		logic [22:0] rsvd;
		logic upd_kind;
		logic done_rel;
		logic busy;
		logic err;
		logic mode_ok;
		logic [3:0] stage;
	} ppac_stat_s;
endpackage

// file: verilog/ppac_sync.sv
/*
 Two-flop synchroniser for a vector of independent level inputs.
 Assumes each bit is an unrelated asynchronous level.
*/
`timescale 1ns/1ps
module ppac_sync #(
	parameter int W = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	genvar i;
	// One chain per bit; the first stage feeds only the second
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_r;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					meta_r <= RST_VAL[i];
					q[i] <= RST_VAL[i];
				end else begin
					meta_r <= d[i];
					q[i] <= meta_r;
				end
			end
		end
	endgenerate
endmodule

// file: verilog/ppac_timer.sv
/*
 Down-counting delay timer with a one-cycle expiry pulse.
 Assumes start is a single-cycle pulse and load is at least one.
*/
`timescale 1ns/1ps
module ppac_timer
	import ppac_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire ppac_pkg::ppac_tmr_t load,
	output logic done_r
);
	ppac_tmr_t cnt_r;

	// Load on start, count to zero, pulse on the last step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (start) begin
				cnt_r <= load;
			end else if (cnt_r != '0) begin
				cnt_r <= cnt_r - TMR_W'(1);
				done_r <= (cnt_r == TMR_W'(1));
			end
		end
	end
endmodule

// file: verilog/ppac_top.sv
/*
 Device side of a byte-wide asynchronous configuration port, with an
 AXI4-Lite register slave. Assumes pins synchronous to aclk, open-drain
 lines resolved outside from the active-low enables.
*/
// Notes on behaviour
// (RULE1) Host sets mode pins 0001 or 0101
// (RULE2) No decompression or security in this scheme
// (RULE3) Host uses either select; other tied active
// (RULE4) Power-on delay 100 ms low, 12 ms high
// (RULE5) Power-on: status low, user pins tri-stated
// (RULE6) Pull-ups on unless pull-up disable pin high; the code keeps them off in the power-on and user stages
// (RULE7) Stay in reset while restart or status low
// (RULE8) Host starts by raising config restart
// (RULE9) Restart high releases status, then accept bytes
// (RULE10) Host selects, presents byte, pulses write strobe
// (RULE11) Write strobe rise captures byte, busy asserted
// (RULE12) Process byte, then signal ready again
// (RULE13) Host sends next byte only when ready
// (RULE14) Read strobe low puts ready on msb
// (RULE15) Host may wait worst-case time instead
// (RULE16) Host checks status and done per byte
// (RULE17) Done released one byte before final byte
// (RULE18) Initialise only when done line is high
// (RULE19) Default init uses internal slow oscillator count
// (RULE20) User clock: delay, then 299 cycles
// (RULE21) User clock never affects byte loading
// (RULE22) Error pulls status low; auto-restart time-out
// (RULE23) Host restarts with two microsecond low pulse
// (RULE24) Strobes and selects synchronised before use; the byte hold register follows the raw write strobe
// (RULE25) Drive byte bus only on selected read
`timescale 1ns/1ps
module ppac_top #(
	parameter int POR_LONG = ppac_pkg::POR_LONG_CYC,
	parameter int POR_SHORT = ppac_pkg::POR_SHORT_CYC,
	parameter int ERR_TMO = ppac_pkg::ERR_TMO_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ppac_pkg::AW-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ppac_pkg::AW-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic [3:0] mode_select_pins,
	input wire logic update_kind_select,
	input wire logic por_delay_select,
	input wire logic io_pullup_enable_n,
	input wire logic config_restart_n,
	input wire logic status_error_n_in,
	output logic status_error_n_out,
	output logic status_error_n_oe_n,
	input wire logic cfg_done_in,
	output logic cfg_done_out,
	output logic cfg_done_oe_n,
	input wire logic select_low,
	input wire logic select_high,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic [7:0] byte_bus_in,
	output logic [7:0] byte_bus_out,
	output logic byte_bus_oe_n,
	output logic ready_not_busy,
	input wire logic user_init_clock,
	output logic user_pins_tristate,
	output logic weak_pullup_on,
	output logic [7:0] cfg_byte,
	output logic cfg_byte_valid
);
	import ppac_pkg::*;

	ppac_stage_e stage_r;
	ppac_ctrl_s ctrl_r;
	ppac_stat_s stat_w;
	logic [S_W-1:0] sync_w;
	logic ws_d_r, uclk_d_r, tmr_start_r, tmr_done, upd_r;
	logic ws_rise, uclk_rise, sel_s, rs_s, restart_s, stat_s, done_s;
	logic mode_ok, acc_w, hdr_bad;
	ppac_tmr_t tmr_load_r;
	logic [7:0] hold_r;
	logic [31:0] flen_r, bcnt_r, err_cyc_r;
	logic [UCNT_W-1:0] uclk_cnt_r;
	logic aw_got_r, w_got_r;
	logic [AW-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic [31:0] rd_data;
	logic rd_err;

	// Strobes, selects and open-drain lines into the clock domain
	ppac_sync #(.W(S_W), .RST_VAL(SYNC_RST)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({user_init_clock, cfg_done_in, status_error_n_in, config_restart_n,
			select_high, select_low, read_strobe_n, write_strobe_n}),
		.q(sync_w)
	); // see (RULE24)

	ppac_timer u_tmr (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(tmr_start_r),
		.load(tmr_load_r),
		.done_r(tmr_done)
	);

	// Decoded synchronised pins; mode pins and header byte are used directly
	assign sel_s = !sync_w[S_SL] && sync_w[S_SH];
	assign rs_s = sync_w[S_RS];
	assign restart_s = sync_w[S_RST];
	assign stat_s = sync_w[S_STAT];
	assign done_s = sync_w[S_DONE];
	assign ws_rise = sync_w[S_WS] && !ws_d_r;
	assign uclk_rise = sync_w[S_UCLK] && !uclk_d_r;
	assign mode_ok = (mode_select_pins == MODE_PLAIN) || (mode_select_pins == MODE_UPGRADE);
	assign acc_w = stage_r == ST_CONFIG && stat_s && restart_s && ready_not_busy
		&& bcnt_r != flen_r && ws_rise && sel_s;
	assign hdr_bad = cfg_byte[HDR_CMP_BIT] || cfg_byte[HDR_SEC_BIT];

	// Edge history; the data byte follows the raw strobe so it is
	// held from the strobe's own rising edge, not the synced one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ws_d_r <= 1'b1;
			uclk_d_r <= 1'b0;
			hold_r <= 8'h00;
		end else begin
			ws_d_r <= sync_w[S_WS];
			uclk_d_r <= sync_w[S_UCLK];
			if (!write_strobe_n) begin
				hold_r <= byte_bus_in;
			end
		end
	end

	// Stage sequencer: reset, configuration, initialisation
	always_ff @(posedge aclk) begin
		tmr_start_r <= 1'b0;
		cfg_byte_valid <= 1'b0;
		if (!aresetn) begin
			stage_r <= ST_PORA;
			ready_not_busy <= 1'b1;
			cfg_done_oe_n <= 1'b0;
			bcnt_r <= 32'h0000_0000;
			tmr_load_r <= '0;
			uclk_cnt_r <= '0;
			cfg_byte <= 8'h00;
			upd_r <= 1'b0;
			tmr_start_r <= 1'b0;
		end else if (stage_r != ST_PORA && stage_r != ST_POR && stage_r != ST_RESET
			&& (!restart_s || (!stat_s && stage_r != ST_ERROR))) begin
			stage_r <= ST_RESET; // see (RULE7)
			ready_not_busy <= 1'b1;
			cfg_done_oe_n <= 1'b0;
		end else begin
			case (stage_r)
				ST_PORA: begin
					tmr_load_r <= por_delay_select ? TMR_W'(POR_SHORT) : TMR_W'(POR_LONG); // see (RULE4)
					tmr_start_r <= 1'b1;
					stage_r <= ST_POR;
				end
				ST_POR: begin
					if (tmr_done) begin
						stage_r <= ST_RESET;
					end
				end
				ST_RESET: begin
					bcnt_r <= 32'h0000_0000;
					uclk_cnt_r <= '0;
					cfg_done_oe_n <= 1'b0;
					ready_not_busy <= 1'b1;
					upd_r <= update_kind_select;
					// Line must actually read high before bytes count
					if (restart_s && stat_s) begin
						stage_r <= mode_ok ? ST_CONFIG : ST_ERROR; // see (RULE9)
						tmr_load_r <= TMR_W'(ERR_TMO);
						tmr_start_r <= !mode_ok;
					end
				end
				ST_CONFIG: begin
					if (!ready_not_busy) begin
						if (tmr_done) begin
							ready_not_busy <= 1'b1; // see (RULE12)
							bcnt_r <= bcnt_r + 32'h0000_0001;
							cfg_byte_valid <= 1'b1;
							// Compressed or secured files are refused here
							if (bcnt_r == 32'h0000_0000 && hdr_bad) begin
								stage_r <= ST_ERROR; // see (RULE2)
								tmr_load_r <= TMR_W'(ERR_TMO);
								tmr_start_r <= 1'b1;
							end
						end
					end else if (acc_w) begin
						cfg_byte <= hold_r;
						ready_not_busy <= 1'b0; // see (RULE11)
						tmr_load_r <= TMR_W'(BUSY_CYC);
						tmr_start_r <= 1'b1;
					end else if (bcnt_r == flen_r) begin
						// Init waits for the pulled-up line itself
						if (done_s) begin
							stage_r <= ctrl_r.use_uclk ? ST_INITD : ST_INIT; // see (RULE18)
							tmr_load_r <= ctrl_r.use_uclk ? TMR_W'(D2U_CYC) : TMR_W'(INIT_INT_CYC); // see (RULE19)
							tmr_start_r <= 1'b1;
						end
					end
					if (ready_not_busy && flen_r != 32'h0000_0000
						&& bcnt_r + 32'h0000_0001 >= flen_r) begin
						cfg_done_oe_n <= 1'b1; // see (RULE17)
					end
				end
				ST_ERROR: begin
					ready_not_busy <= 1'b1;
					if (ctrl_r.auto_rst && tmr_done) begin
						stage_r <= ST_RESET; // see (RULE22)
					end
				end
				ST_INITD: begin
					if (tmr_done) begin
						stage_r <= ST_INIT;
					end
				end
				ST_INIT: begin
					// User clock only counts here, never during loading
					if (ctrl_r.use_uclk) begin
						if (uclk_rise) begin
							uclk_cnt_r <= uclk_cnt_r + UCNT_W'(1); // see (RULE20) (RULE21)
							if (uclk_cnt_r == UCNT_W'(INIT_CLKS - 1)) begin
								stage_r <= ST_USER;
							end
						end
					end else if (tmr_done) begin
						stage_r <= ST_USER; // see (RULE19)
					end
				end
				ST_USER: begin
					stage_r <= ST_USER;
				end
				default: begin
					stage_r <= ST_RESET;
				end
			endcase
		end
	end

	// Pin drivers: status line, read-back, user pin state
	always_ff @(posedge aclk) begin
		status_error_n_out <= 1'b0;
		cfg_done_out <= 1'b0;
		if (!aresetn) begin
			status_error_n_oe_n <= 1'b0;
			byte_bus_oe_n <= 1'b1;
			byte_bus_out <= 8'h00;
			user_pins_tristate <= 1'b1;
			weak_pullup_on <= 1'b0;
		end else begin
			status_error_n_oe_n <= !(stage_r == ST_PORA || stage_r == ST_POR
				|| stage_r == ST_ERROR || (stage_r == ST_RESET && !restart_s)); // see (RULE5) (RULE9)
			byte_bus_oe_n <= !(stage_r == ST_CONFIG && !rs_s && sel_s); // see (RULE25)
			byte_bus_out <= {ready_not_busy, 7'h00}; // see (RULE14)
			user_pins_tristate <= stage_r != ST_USER;
			weak_pullup_on <= !io_pullup_enable_n && stage_r != ST_USER
				&& stage_r != ST_PORA && stage_r != ST_POR; // see (RULE6)
		end
	end

	// Status word seen by software
	always_comb begin
		stat_w = '0;
		stat_w.stage = stage_r;
		stat_w.mode_ok = mode_ok;
		stat_w.err = stage_r == ST_ERROR;
		stat_w.busy = !ready_not_busy;
		stat_w.done_rel = cfg_done_oe_n;
		stat_w.upd_kind = upd_r;
	end

	// Read decode; unmapped addresses answer with a slave error
	always_comb begin
		rd_err = 1'b0;
		case (araddr)
			A_CTRL: rd_data = ctrl_r;
			A_FLEN: rd_data = flen_r;
			A_STAT: rd_data = stat_w;
			A_BCNT: rd_data = bcnt_r;
			A_LAST: rd_data = {24'h00_0000, cfg_byte};
			default: begin
				rd_data = 32'h0000_0000;
				rd_err = 1'b1;
			end
		endcase
	end

	// Byte-lane merge for partial writes
	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Write channel: address and data in either order, one at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OK;
			ctrl_r <= '0;
			flen_r <= FLEN_RST;
		end else begin
			if (awvalid && awready) begin
				aw_addr_r <= awaddr;
				aw_got_r <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_data_r <= wdata;
				w_strb_r <= wstrb;
				w_got_r <= 1'b1;
				wready <= 1'b0;
			end
			if (aw_got_r && w_got_r && !bvalid) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= RESP_OK;
				case (aw_addr_r)
					A_CTRL: ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_0003;
					A_FLEN: flen_r <= merge(flen_r, w_data_r, w_strb_r);
					A_STAT, A_BCNT, A_LAST: bresp <= RESP_OK;
					default: bresp <= RESP_SLVERR;
				endcase
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// Read channel: data registered one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OK;
		end else begin
			if (arvalid && arready) begin
				rdata <= rd_data;
				rresp <= rd_err ? RESP_SLVERR : RESP_OK;
				rvalid <= 1'b1;
				arready <= 1'b0;
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// Helper: cycles spent in the error stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_cyc_r <= 32'h0000_0000;
		end else begin
			err_cyc_r <= (stage_r == ST_ERROR) ? err_cyc_r + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_por_sel;
		$rose(stage_r == ST_POR) |-> tmr_load_r ==
			($past(por_delay_select) ? TMR_W'(POR_SHORT) : TMR_W'(POR_LONG));
	endproperty
	a_por_sel: assert property (p_por_sel) else $error("por delay load wrong"); // see (RULE4)

	property p_por_hold;
		stage_r == ST_POR |=> !status_error_n_oe_n && user_pins_tristate;
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("status not held in por"); // see (RULE5)

	property p_pull;
		stage_r == ST_CONFIG |=> weak_pullup_on == !$past(io_pullup_enable_n);
	endproperty
	a_pull: assert property (p_pull) else $error("pull-up state wrong"); // see (RULE6)

	property p_reset_hold;
		!restart_s && stage_r == ST_CONFIG |=> stage_r == ST_RESET ##1 !status_error_n_oe_n;
	endproperty
	a_reset_hold: assert property (p_reset_hold) else $error("restart low ignored"); // see (RULE7)

	property p_release;
		stage_r == ST_RESET && restart_s |=> status_error_n_oe_n;
	endproperty
	a_release: assert property (p_release) else $error("status not released"); // see (RULE9)

	property p_busy;
		acc_w |=> !ready_not_busy && cfg_byte == $past(hold_r);
	endproperty
	a_busy: assert property (p_busy) else $error("write not captured"); // see (RULE11)

	property p_ready;
		$fell(ready_not_busy) && restart_s && stat_s |-> !ready_not_busy[*6] ##1 ready_not_busy;
	endproperty
	a_ready: assert property (p_ready) else $error("busy time wrong"); // see (RULE12)

	property p_msb;
		!byte_bus_oe_n |-> byte_bus_out[7] == $past(ready_not_busy);
	endproperty
	a_msb: assert property (p_msb) else $error("msb not ready state"); // see (RULE14)

	property p_drive;
		!byte_bus_oe_n |-> $past(!rs_s && sel_s && stage_r == ST_CONFIG);
	endproperty
	a_drive: assert property (p_drive) else $error("bus driven without read"); // see (RULE25)

	property p_early;
		$rose(cfg_done_oe_n) |-> bcnt_r + 32'h0000_0001 == flen_r;
	endproperty
	a_early: assert property (p_early) else $error("done not one byte early"); // see (RULE17)

	property p_hdr;
		stage_r == ST_CONFIG && !ready_not_busy && tmr_done && restart_s && stat_s
			&& bcnt_r == 32'h0000_0000 && hdr_bad |=> stage_r == ST_ERROR;
	endproperty
	a_hdr: assert property (p_hdr) else $error("compressed file accepted"); // see (RULE2)

	property p_init_gate;
		$past(stage_r) == ST_CONFIG && stage_r inside {ST_INITD, ST_INIT} |-> $past(done_s);
	endproperty
	a_init_gate: assert property (p_init_gate) else $error("init without done line"); // see (RULE18)

	property p_uclk;
		$rose(stage_r == ST_USER) && ctrl_r.use_uclk |-> uclk_cnt_r == UCNT_W'(INIT_CLKS);
	endproperty
	a_uclk: assert property (p_uclk) else $error("user clock count wrong"); // see (RULE20)

	property p_err_tmo;
		ctrl_r.auto_rst && stage_r == ST_ERROR |-> err_cyc_r <= 32'(ERR_TMO + 4);
	endproperty
	a_err_tmo: assert property (p_err_tmo) else $error("error time-out too long"); // see (RULE22)

	// Main scenarios
	c_user: cover property ($rose(stage_r == ST_USER));
	c_error: cover property ($rose(stage_r == ST_ERROR));
	c_read: cover property ($fell(byte_bus_oe_n));
	c_byte: cover property (cfg_byte_valid);
endmodule

// file: sim/ppac_host.sv
/*
 Host model for the configuration port: restart, select, strobes, byte bus.
 Assumes the bench resolves the shared byte bus and the open-drain lines.
*/
`timescale 1ns/1ps
module ppac_host (
	input wire logic aclk,
	input wire logic status_ln,
	input wire logic ready,
	input wire logic [7:0] bus,
	output logic restart_n,
	output logic sel_n,
	output logic ws_n,
	output logic rs_n,
	output logic drv,
	output logic [7:0] d
);
	// Idle pins; restart stays low until asked for
	initial begin
		restart_n = 1'b0;
		sel_n = 1'b1;
		ws_n = 1'b1;
		rs_n = 1'b1;
		drv = 1'b0;
		d = 8'h00;
	end

	// Long low pulse, then rise; waits a bounded time for the released line
	task automatic restart(output bit ok);
		int i;
		@(posedge aclk) restart_n <= 1'b0;
		repeat (250) @(posedge aclk);
		restart_n <= 1'b1;
		ok = 1'b0;
		for (i = 0; i < 200 && !ok; i++) begin
			@(negedge aclk) ok = status_ln === 1'b1;
		end
	endtask

	// One byte; n counts the cycles ready stays low
	task automatic wr_byte(input logic [7:0] b, output int n);
		int i;
		@(posedge aclk) begin
			sel_n <= 1'b0;
			drv <= 1'b1;
			d <= b;
			ws_n <= 1'b0;
		end
		repeat (2) @(posedge aclk);
		ws_n <= 1'b1;
		n = 0;
		for (i = 0; i < 20 && ready !== 1'b0; i++) @(negedge aclk);
		for (i = 0; i < 50 && ready !== 1'b1; i++) begin
			@(negedge aclk);
			n++;
		end
		// Next byte only once ready is back
		@(posedge aclk) drv <= 1'b0;
	endtask

	// Fixed worst-case wait instead of polling; read strobe stays high
	task automatic wr_wait(input logic [7:0] b, input int w);
		@(posedge aclk) begin
			drv <= 1'b1;
			d <= b;
			ws_n <= 1'b0;
		end
		repeat (2) @(posedge aclk);
		ws_n <= 1'b1;
		repeat (w) @(posedge aclk);
		drv <= 1'b0;
	endtask

	// Status poll on the bus; host lets go of the bus first
	task automatic rd_stat(output logic [7:0] v);
		@(posedge aclk) begin
			sel_n <= 1'b0;
			drv <= 1'b0;
			rs_n <= 1'b0;
		end
		repeat (6) @(negedge aclk);
		v = bus;
		@(posedge aclk) rs_n <= 1'b1;
	endtask
endmodule

// file: sim/tb.sv
/*
 Self-checking bench: AXI4-Lite master, host model, line resolution and
 a queue-fed result monitor. Assumes shortened power-on and time-out counts.
*/
`timescale 1ns/1ps
module tb;
	import ppac_pkg::*;
	localparam int PL = 50;
	localparam int PS = 20;
	localparam int ET = 30;
	localparam logic [33:0] ALL = 34'h3FFFFFFFF;
	localparam logic [33:0] SM = 34'hF;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] mode = MODE_PLAIN;
	logic upk = 1'b0, pds = 1'b0, pun = 1'b0, st_pd_n = 1'b1, dn_pd_n = 1'b1;
	logic uclk = 1'b0, uen = 1'b0;
	logic [1:0] ph = 2'h0;
	logic awready, wready, bvalid, arready, rvalid, st_oe_n, dn_oe_n, bus_oe_n;
	logic rdy, cbv, upt, wpu, rst_n, sel_n, ws_n, rs_n, hdrv, st_ln, dn_ln, st_out, dn_out;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] bus_out, cbyte, hd, bus;
	logic [33:0] m;
	int n_errors = 0, checked = 0;
	logic [7:0] qb[$];
	logic [33:0] qr[$], qm[$];

	always #4 aclk = ~aclk;

	// Pull-ups on the open-drain lines; undriven bus shows the inverse
	assign st_ln = (st_oe_n | st_out) & st_pd_n;
	assign dn_ln = (dn_oe_n | dn_out) & dn_pd_n;
	assign bus = !bus_oe_n ? bus_out : hdrv ? hd : ~hd;

	// User init clock at a quarter of the core rate
	always @(posedge aclk) begin
		if (uen) begin
			ph <= ph + 2'h1;
			uclk <= ph[1];
		end
	end

	ppac_top #(.POR_LONG(PL), .POR_SHORT(PS), .ERR_TMO(ET)) ppac_top_i (
		.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
		.wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
		.arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .mode_select_pins(mode),
		.update_kind_select(upk), .por_delay_select(pds), .io_pullup_enable_n(pun),
		.config_restart_n(rst_n), .status_error_n_in(st_ln), .status_error_n_out(st_out),
		.status_error_n_oe_n(st_oe_n), .cfg_done_in(dn_ln), .cfg_done_out(dn_out),
		.cfg_done_oe_n(dn_oe_n), .select_low(sel_n), .select_high(1'b1),
		.write_strobe_n(ws_n), .read_strobe_n(rs_n), .byte_bus_in(bus),
		.byte_bus_out(bus_out), .byte_bus_oe_n(bus_oe_n), .ready_not_busy(rdy),
		.user_init_clock(uclk), .user_pins_tristate(upt), .weak_pullup_on(wpu),
		.cfg_byte(cbyte), .cfg_byte_valid(cbv));

	ppac_host ppac_host_i (.aclk, .status_ln(st_ln), .ready(rdy), .bus, .restart_n(rst_n),
		.sel_n, .ws_n, .rs_n, .drv(hdrv), .d(hd));

	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic tmo(input string nm);
		n_errors++;
		$display("Error %s expected answer seen timeout", nm);
		summarize();
	endtask

	// Monitor: each result takes the oldest note off its queue
	always @(posedge aclk) begin
		if (cbv === 1'b1 && qb.size() > 0) chk("cfg_byte", {26'h0, qb.pop_front()}, {26'h0, cbyte});
		if (rvalid === 1'b1 && rready === 1'b1 && qr.size() > 0) begin
			m = qm.pop_front();
			chk("rdata", qr.pop_front() & m, {rresp, rdata} & m);
		end
	end

	task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
		int i;
		@(posedge aclk) begin
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			awaddr <= a;
			wdata <= v;
			bready <= 1'b1;
		end
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		if (i == 50) tmo("bvalid");
		chk("bresp", {32'h0, r}, {32'h0, bresp});
	endtask

	task automatic axr(input logic [7:0] a, input logic [33:0] e, input logic [33:0] k);
		int i;
		qr.push_back(e);
		qm.push_back(k);
		@(posedge aclk) begin
			arvalid <= 1'b1;
			araddr <= a;
			rready <= 1'b1;
		end
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		if (i == 50) tmo("rvalid");
	endtask

	task automatic wait_user(input int lim);
		int i;
		for (i = 0; i < lim && upt !== 1'b0; i++) @(negedge aclk);
		if (i == lim) tmo("user mode");
	endtask

	task automatic por(input logic s, input int n);
		@(posedge aclk) begin
			aresetn <= 1'b0;
			pds <= s;
			pun <= s;
		end
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (n - 10) @(posedge aclk);
		chk("status drive", 34'h0, {33'h0, st_oe_n});
		chk("pins tristate", 34'h1, {33'h0, upt});
		axr(A_STAT, 34'(ST_POR), SM);
		repeat (20) @(posedge aclk);
		axr(A_STAT, 34'(ST_RESET), SM);
		chk("pull-ups", {33'h0, !s}, {33'h0, wpu});
		$display("power-on test done");
	endtask

	task automatic load(input int len);
		int n;
		bit ok;
		logic [7:0] b;
		axw(A_FLEN, 32'(len), RESP_OK);
		ppac_host_i.restart(ok);
		chk("status released", 34'h1, {33'h0, ok});
		repeat (3) @(posedge aclk); // Line must pass the synchroniser first
		axr(A_STAT, {25'h0, upk, 4'h0, 4'(ST_CONFIG)}, 34'h10F);
		ppac_host_i.rd_stat(b);
		chk("ready on msb", 34'h80, {26'h0, b});
		repeat (6) @(negedge aclk);
		chk("bus released", 34'h1, {33'h0, bus_oe_n});
		for (int i = 0; i < len; i++) begin
			b = 8'($urandom) & (i == 0 ? 8'hFC : 8'hFF);
			qb.push_back(b);
			if (i == len - 1) begin
				ppac_host_i.wr_wait(b, 12);
				chk("ready after wait", 34'h1, {33'h0, rdy});
			end else begin
				ppac_host_i.wr_byte(b, n);
				chk("busy cycles", 34'h6, 34'(n));
			end
			repeat (2) @(negedge aclk);
			chk("done release", {33'h0, i >= len - 2}, {33'h0, dn_oe_n});
			chk("status line", 34'h1, {33'h0, st_ln});
		end
		chk("bytes left", 34'h0, 34'(qb.size()));
	endtask

	initial begin
		int i;
		int n;
		bit ok;
		void'($urandom(32'h1E86));
		por(1'b0, PL);
		por(1'b1, PS);
		axr(A_CTRL, 34'h0, ALL);
		axr(A_FLEN, {2'h0, FLEN_RST}, ALL);
		axr(8'h14, {RESP_SLVERR, 32'h0}, ALL);
		axw(8'h14, 32'h0, RESP_SLVERR);
		axw(A_STAT, 32'hFFFFFFFF, RESP_OK);
		axr(A_STAT, 34'(ST_RESET), SM);
		$display("register test done");
		// Plain load with the done line held low from outside
		@(posedge aclk) begin
			dn_pd_n <= 1'b0;
			pun <= 1'b0;
		end
		load(4);
		repeat (4000) @(posedge aclk);
		chk("held before init", 34'h1, {33'h0, upt});
		dn_pd_n <= 1'b1;
		wait_user(4500);
		chk("pull-ups off", 34'h0, {33'h0, wpu});
		axr(A_STAT, 34'(ST_USER), SM);
		$display("load test done");
		// Status line pulled low by another party
		ppac_host_i.restart(ok);
		@(posedge aclk) st_pd_n <= 1'b0;
		repeat (5) @(posedge aclk);
		axr(A_STAT, 34'(ST_RESET), SM);
		st_pd_n <= 1'b1;
		// Both header flags refused, auto-restart on
		axw(A_CTRL, 32'h1, RESP_OK);
		for (int f = 1; f < 3; f++) begin
			ppac_host_i.restart(ok);
			ppac_host_i.wr_byte(8'(f), n);
			for (i = 0; i < 20 && st_ln !== 1'b0; i++) @(negedge aclk);
			chk("error flagged", 34'h0, {33'h0, st_ln});
			axr(A_STAT, 34'(ST_ERROR), SM);
			for (i = 0; i < ET + 20 && st_ln !== 1'b1; i++) @(negedge aclk);
			chk("auto restart", 34'h1, {33'h0, st_ln});
		end
		$display("error test done");
		// Upgrade mode, initialisation on the user clock
		axw(A_CTRL, 32'h2, RESP_OK);
		@(posedge aclk) begin
			mode <= MODE_UPGRADE;
			upk <= 1'b1;
			uen <= 1'b1;
		end
		load(2);
		repeat (900) @(posedge aclk);
		chk("user clock count", 34'h1, {33'h0, upt});
		wait_user(700);
		$display("user clock test done");
		summarize();
	end
endmodule
